/* File: rtl/tofi_pkg.sv */
// ==========================================================================
// shared constants and types for the sensor two-wire port
package tofi_pkg;
  // bus framing
  localparam logic [6:0] TGT_ADDR7    = 7'h29;   // 0101001, byte 0x52 / 0x53
  localparam logic       DIR_WRITE    = 1'b0;    // direction bit, controller writes
  localparam logic       DIR_READ     = 1'b1;    // direction bit, controller reads
  localparam logic [3:0] BYTE_BITS    = 4'h8;    // data bits before the ack slot
  localparam int         IDX_W        = 16;      // register index width
  localparam int         REG_AW_DEF   = 8;       // index bits backed by storage
  // timing
  localparam int         CLK_HZ       = 40_000_000;
  localparam int         BUS_RATE_HZ  = 1_000_000;  // fastest bit rate supported
  // quarter bit period in core cycles, rounded up so the bus never runs fast
  localparam int         Q_CYC        = (CLK_HZ + 4 * BUS_RATE_HZ - 1) / (4 * BUS_RATE_HZ);
  localparam int         DIV_W        = 8;
  // target states
  typedef enum logic [2:0] {
    T_IDLE   = 3'h0,   // bus free or stopped
    T_RX     = 3'h1,   // shifting a byte in
    T_RX_ACK = 3'h2,   // driving the target ack
    T_TX     = 3'h3,   // shifting a byte out
    T_TX_ACK = 3'h4,   // waiting for the controller ack
    T_IGNORE = 3'h5    // not addressed or read ended, wait for start
  } tofi_tst_t;
  // meaning of the byte the target is receiving
  typedef enum logic [1:0] {
    RL_ADDR = 2'h0,
    RL_IDXH = 2'h1,
    RL_IDXL = 2'h2,
    RL_DATA = 2'h3
  } tofi_role_t;
  // controller states
  typedef enum logic [1:0] {
    C_IDLE  = 2'h0,
    C_START = 2'h1,
    C_BYTE  = 2'h2,
    C_STOP  = 2'h3
  } tofi_cst_t;
  // meaning of the byte the controller is moving
  typedef enum logic [2:0] {
    CR_ADDRW = 3'h0,
    CR_IDXH  = 3'h1,
    CR_IDXL  = 3'h2,
    CR_WDATA = 3'h3,
    CR_ADDRR = 3'h4,
    CR_RDATA = 3'h5
  } tofi_crole_t;
endpackage

/* File: rtl/tofi_bus_if.sv */
`timescale 1ns/1ps
// ==========================================================================
// two-wire bus with pull-ups: a line is low whenever any enable is high
interface tofi_bus_if;
  logic tgt_sda_o;    // target data out, always low
  logic tgt_sda_oe;   // target pulls data low
  logic ctl_sda_o;    // controller data out, always low
  logic ctl_sda_oe;   // controller pulls data low
  logic ctl_scl_o;    // controller clock out, always low
  logic ctl_scl_oe;   // controller pulls clock low
  logic if_sel;       // interface select, high resets the target port
  logic sda;          // resolved data line
  logic scl;          // resolved clock line
  // wired-and of open-drain drivers over the pull-ups
  assign sda = (tgt_sda_oe ? tgt_sda_o : 1'b1) & (ctl_sda_oe ? ctl_sda_o : 1'b1);
  assign scl = ctl_scl_oe ? ctl_scl_o : 1'b1;
  modport tgt (input sda, input scl, input if_sel, output tgt_sda_o, output tgt_sda_oe);
  modport ctl (input sda, input scl, output if_sel, output ctl_sda_o,
               output ctl_sda_oe, output ctl_scl_o, output ctl_scl_oe);
endinterface

/* File: rtl/tofi_target.sv */
`timescale 1ns/1ps
// Functional notes
// - answer only address 0101001, either direction bit
// - address lsb zero writes, one reads
// - eight-bit bytes, each followed by ack slot
// - sample data on rising clock edge
// - data edges during clock high mark start/stop
// - message: start, bytes, then stop or restart
// - ack own address, hold direction for message
// - write: two bytes form sixteen-bit index
// - shift data in, ack, store at index
// - read: load indexed register, shift out on falls
// - receiver acks every byte but the last read byte
// - only controller ends message: stop or nack
// - index increments after every data byte
// - controller streams bytes without resending index
// - lines only pulled low, else released
// - controller makes clock and starts transfers
// - data held stable while clock high
// - works at bit rates up to 1 Mbit/s
// - select pin high resets port, low selects
module tofi_target
  import tofi_pkg::*;
#(
  parameter int REG_AW = REG_AW_DEF   // index bits backed by storage
) (
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_srst,
  // bus side
  tofi_bus_if.tgt                bus,
  // sensor side read port
  input  wire logic [REG_AW-1:0] i_usr_idx,
  output logic      [7:0]        o_usr_data,
  // sensor side write notification
  output logic                   o_wr_stb,
  output logic      [IDX_W-1:0]  o_wr_idx,
  output logic      [7:0]        o_wr_data,
  // status
  output logic                   o_busy
);
  // ========================================================================
  // storage and state
  logic [7:0]       regs [2**REG_AW];  // sensor registers, no reset
  tofi_tst_t        st_q, st_d;        // byte-level state
  tofi_role_t       role_q, role_d;    // meaning of byte being received
  logic [3:0]       cnt_q, cnt_d;      // bits moved in this byte
  logic [7:0]       sh_q, sh_d;        // serial/parallel register
  logic [IDX_W-1:0] idx_q, idx_d;      // current register index
  logic             rnw_q, rnw_d;      // latched direction
  logic             oe_q, oe_d;        // pulling data low
  logic             wr_d;              // store strobe
  logic             scl_q, sda_q;      // previous line samples
  logic             port_rst;          // reset of the whole port
  logic             scl_rise, scl_fall;
  logic             start_ev, stop_ev;
  logic [7:0]       rd_byte;           // register at current index

  // ========================================================================
  // line events
  // select pin reset
  assign port_rst = i_srst | bus.if_sel;
  // 40 core cycles per bit at full rate
  assign scl_rise = bus.scl & ~scl_q;
  assign scl_fall = ~bus.scl & scl_q;
  assign start_ev = bus.scl & scl_q & sda_q & ~bus.sda;
  assign stop_ev  = bus.scl & scl_q & ~sda_q & bus.sda;
  assign rd_byte  = regs[idx_q[REG_AW-1:0]];

  // ========================================================================
  // protocol next state
  always_comb begin
    st_d   = st_q;
    role_d = role_q;
    cnt_d  = cnt_q;
    sh_d   = sh_q;
    idx_d  = idx_q;
    rnw_d  = rnw_q;
    oe_d   = oe_q;
    wr_d   = 1'b0;
    case (st_q)
      T_RX: begin
        if (scl_rise && cnt_q != BYTE_BITS) begin
          sh_d  = {sh_q[6:0], bus.sda};
          cnt_d = cnt_q + 4'h1;
        end else if (scl_fall && cnt_q == BYTE_BITS) begin
          st_d  = T_RX_ACK;
          oe_d  = 1'b1;
          cnt_d = 4'h0;
          case (role_q)
            RL_ADDR: begin
              if (sh_q[7:1] == TGT_ADDR7) begin
                rnw_d = sh_q[0];
              end else begin
                // foreign address: stay off the bus
                st_d = T_IGNORE;
                oe_d = 1'b0;
              end
            end
            RL_IDXH: idx_d[15:8] = sh_q;
            RL_IDXL: idx_d[7:0]  = sh_q;
            default: begin
              wr_d  = 1'b1;
              idx_d = idx_q + 16'h0001;
            end
          endcase
        end
      end
      T_RX_ACK: begin
        // ack held through one clock pulse
        if (scl_fall) begin
          oe_d = 1'b0;
          if (role_q == RL_ADDR && rnw_q == DIR_READ) begin
            st_d  = T_TX;
            sh_d  = rd_byte;
            oe_d  = ~rd_byte[7];
            cnt_d = 4'h1;
            idx_d = idx_q + 16'h0001;
          end else begin
            st_d = T_RX;
            case (role_q)
              RL_ADDR: role_d = RL_IDXH;
              RL_IDXH: role_d = RL_IDXL;
              default: role_d = RL_DATA;
            endcase
          end
        end
      end
      T_TX: begin
        // data only moves after clock falls
        if (scl_fall) begin
          if (cnt_q == BYTE_BITS) begin
            oe_d = 1'b0;
            st_d = T_TX_ACK;
          end else begin
            sh_d  = {sh_q[6:0], 1'b0};
            oe_d  = ~sh_q[6];
            cnt_d = cnt_q + 4'h1;
          end
        end
      end
      T_TX_ACK: begin
        if (scl_rise && bus.sda) begin
          st_d = T_IGNORE;
        end else if (scl_fall) begin
          st_d  = T_TX;
          sh_d  = rd_byte;
          oe_d  = ~rd_byte[7];
          cnt_d = 4'h1;
          idx_d = idx_q + 16'h0001;
        end
      end
      default: begin
        // idle and ignore wait for a start
        oe_d = 1'b0;
      end
    endcase
    if (start_ev) begin
      st_d   = T_RX;
      role_d = RL_ADDR;
      cnt_d  = 4'h0;
      oe_d   = 1'b0;
    end else if (stop_ev) begin
      st_d = T_IDLE;
      oe_d = 1'b0;
    end
  end

  // ========================================================================
  // protocol registers
  always_ff @(posedge i_core_clk) begin
    if (port_rst) begin
      st_q      <= T_IDLE;
      role_q    <= RL_ADDR;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      idx_q     <= '0;
      rnw_q     <= DIR_WRITE;
      oe_q      <= 1'b0;
      scl_q     <= 1'b1;
      sda_q     <= 1'b1;
      o_wr_stb  <= 1'b0;
      o_wr_idx  <= '0;
      o_wr_data <= 8'h00;
    end else begin
      st_q      <= st_d;
      role_q    <= role_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      idx_q     <= idx_d;
      rnw_q     <= rnw_d;
      oe_q      <= oe_d;
      scl_q     <= bus.scl;
      sda_q     <= bus.sda;
      o_wr_stb  <= wr_d;
      o_wr_idx  <= wr_d ? idx_q : o_wr_idx;
      o_wr_data <= wr_d ? sh_q : o_wr_data;
    end
  end

  // ========================================================================
  // register array and sensor read port
  always_ff @(posedge i_core_clk) begin
    // a port reset in the store cycle stores nothing, like the strobe
    if (wr_d && !port_rst) begin
      regs[idx_q[REG_AW-1:0]] <= sh_q;
    end
    if (i_srst) begin
      o_usr_data <= 8'h00;
    end else begin
      o_usr_data <= regs[i_usr_idx];
    end
  end

  // ========================================================================
  // pins
  // open drain, only ever low
  assign bus.tgt_sda_o  = 1'b0;
  assign bus.tgt_sda_oe = oe_q;
  assign o_busy         = (st_q != T_IDLE);
endmodule

/* File: rtl/tofi_ctrl.sv */
`timescale 1ns/1ps
// ==========================================================================
// host end: walks whole write and read messages on command
module tofi_ctrl
  import tofi_pkg::*;
(
  // clock and reset
  input  wire logic             i_core_clk,
  input  wire logic             i_srst,
  // bus side
  tofi_bus_if.ctl               bus,
  // command port
  input  wire logic             i_cmd_valid,
  output logic                  o_cmd_ready,
  input  wire logic             i_cmd_rnw,
  input  wire logic [IDX_W-1:0] i_cmd_idx,
  input  wire logic [7:0]       i_cmd_len,
  // write data, taken on o_wr_take
  input  wire logic [7:0]       i_wr_data,
  output logic                  o_wr_take,
  // read data and completion
  output logic [7:0]            o_rd_data,
  output logic                  o_rd_valid,
  output logic                  o_done,
  output logic                  o_nack,
  // port reset request, drives the select pin
  input  wire logic             i_bus_rst
);
  // ========================================================================
  // state
  tofi_cst_t        cst_q, cst_d;     // message phase
  tofi_crole_t      crl_q, crl_d;     // current byte meaning
  tofi_crole_t      nrl;              // meaning of next byte
  logic             go;               // begin next byte
  logic [1:0]       q_q, q_d;         // quarter within bit
  logic [3:0]       bit_q, bit_d;     // bit within byte, 8 is ack
  logic [7:0]       sh_q, sh_d;       // byte shifter
  logic [7:0]       rem_q, rem_d;     // data bytes left
  logic [IDX_W-1:0] idx_q, idx_d;     // register index
  logic             rnw_q, rnw_d;     // read message
  logic             scl_oe_q, scl_oe_d;
  logic             sda_oe_q, sda_oe_d;
  logic             nk_q, nk_d;       // target withheld ack
  logic             txing;            // controller sends this byte
  logic [DIV_W-1:0] div_q;            // quarter bit divider
  logic             tick;             // quarter bit enable
  logic             sel_q;            // select pin

  assign tick        = (div_q == DIV_W'(Q_CYC - 1));
  assign txing       = (crl_q != CR_RDATA);
  assign o_cmd_ready = (cst_q == C_IDLE) && !sel_q;

  // ========================================================================
  // message next state
  always_comb begin
    cst_d = cst_q; crl_d = crl_q; q_d = q_q; bit_d = bit_q;
    sh_d = sh_q; rem_d = rem_q; idx_d = idx_q; rnw_d = rnw_q;
    scl_oe_d = scl_oe_q; sda_oe_d = sda_oe_q; nk_d = nk_q;
    nrl = crl_q;
    go = 1'b0;
    o_wr_take = 1'b0;
    o_rd_valid = 1'b0;
    o_done = 1'b0;
    if (cst_q == C_IDLE) begin
      if (i_cmd_valid && o_cmd_ready) begin
        cst_d = C_START; crl_d = CR_ADDRW; q_d = 2'h0;
        rnw_d = i_cmd_rnw; idx_d = i_cmd_idx; rem_d = i_cmd_len; nk_d = 1'b0;
      end
    end else if (tick) begin
      q_d = q_q + 2'h1;
      case (cst_q)
        C_START: begin
          case (q_q)
            2'h0: sda_oe_d = 1'b0;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b1;
            default: begin
              scl_oe_d = 1'b1;
              go = 1'b1;
            end
          endcase
        end
        C_BYTE: begin
          case (q_q)
            // data set only while clock low
            2'h0: sda_oe_d = (bit_q != BYTE_BITS) ? (txing & ~sh_q[7])
                           // ack all read bytes but the last
                           : (!txing && rem_q != 8'h01);
            2'h1: scl_oe_d = 1'b0;
            2'h2: begin
              if (bit_q != BYTE_BITS && !txing) sh_d = {sh_q[6:0], bus.sda};
              if (bit_q == BYTE_BITS && txing) nk_d = bus.sda;
            end
            default: begin
              scl_oe_d = 1'b1;
              if (bit_q != BYTE_BITS) begin
                if (txing) sh_d = {sh_q[6:0], 1'b0};
                bit_d = bit_q + 4'h1;
              end else begin
                go = 1'b1;
                case (crl_q)
                  CR_ADDRW: nrl = CR_IDXH;
                  CR_IDXH:  nrl = CR_IDXL;
                  CR_ADDRR: nrl = CR_RDATA;
                  CR_IDXL: begin
                    nrl = CR_WDATA;
                    if (rnw_q) begin
                      go = 1'b0; cst_d = C_START; crl_d = CR_ADDRR;
                    end
                  end
                  CR_WDATA: begin
                    rem_d = rem_q - 8'h01;
                    if (rem_q == 8'h01) begin
                      go = 1'b0; cst_d = C_STOP;
                    end
                  end
                  default: begin
                    o_rd_valid = 1'b1;
                    rem_d = rem_q - 8'h01;
                    if (rem_q == 8'h01) begin
                      go = 1'b0; cst_d = C_STOP;
                    end
                  end
                endcase
                if (txing && nk_d) begin
                  go = 1'b0; cst_d = C_STOP;
                end
              end
            end
          endcase
        end
        default: begin
          case (q_q)
            2'h0: sda_oe_d = 1'b1;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b0;
            default: begin
              cst_d = C_IDLE;
              o_done = 1'b1;
            end
          endcase
        end
      endcase
      if (go) begin
        cst_d = C_BYTE; crl_d = nrl; bit_d = 4'h0;
        case (nrl)
          CR_ADDRW: sh_d = {TGT_ADDR7, DIR_WRITE};
          CR_ADDRR: sh_d = {TGT_ADDR7, DIR_READ};
          CR_IDXH:  sh_d = idx_q[15:8];
          CR_IDXL:  sh_d = idx_q[7:0];
          CR_WDATA: begin
            sh_d = i_wr_data;
            o_wr_take = 1'b1;
          end
          default:  sh_d = 8'hFF;
        endcase
      end
    end
    if (sel_q) begin
      cst_d = C_IDLE; scl_oe_d = 1'b0; sda_oe_d = 1'b0;
    end
  end

  // ========================================================================
  // registers
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      cst_q <= C_IDLE; crl_q <= CR_ADDRW; q_q <= 2'h0; bit_q <= 4'h0;
      sh_q <= 8'h00; rem_q <= 8'h00; idx_q <= '0; rnw_q <= 1'b0;
      scl_oe_q <= 1'b0; sda_oe_q <= 1'b0; nk_q <= 1'b0;
      div_q <= '0; sel_q <= 1'b0; o_rd_data <= 8'h00; o_nack <= 1'b0;
    end else begin
      cst_q <= cst_d; crl_q <= crl_d; q_q <= q_d; bit_q <= bit_d;
      sh_q <= sh_d; rem_q <= rem_d; idx_q <= idx_d; rnw_q <= rnw_d;
      scl_oe_q <= scl_oe_d; sda_oe_q <= sda_oe_d; nk_q <= nk_d;
      div_q <= tick ? '0 : div_q + DIV_W'(1);
      sel_q <= i_bus_rst;
      o_rd_data <= o_rd_valid ? sh_q : o_rd_data;
      o_nack <= nk_d;
    end
  end

  // ========================================================================
  // pins
  // lines only pulled low
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_scl_o  = 1'b0;
  assign bus.ctl_sda_oe = sda_oe_q;
  assign bus.ctl_scl_oe = scl_oe_q;
  assign bus.if_sel     = sel_q;
endmodule

/* File: tb/tofi_bus_properties.sv */
`timescale 1ns/1ps
// ==========================================================================
// wire checks between the host end and the target end
module tofi_bus_properties
  import tofi_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_srst,
  // bus drivers and resolved lines
  input wire logic tgt_sda_oe,
  input wire logic ctl_sda_oe,
  input wire logic ctl_scl_oe,
  input wire logic if_sel,
  input wire logic sda,
  input wire logic scl
);
  logic       sda_q, scl_q;   // lines one cycle back
  logic [3:0] bit_q, bit_d;   // bit slot, 8 is the ack slot
  logic [7:0] sh_q, sh_d;     // bits taken on rising clock
  logic [7:0] hi_q, hi_d;     // cycles with clock high, saturating
  logic       fst_q, fst_d;   // first byte after a start
  logic       wr_q, wr_d;     // addressed for writing
  logic       rd_q, rd_d;     // addressed for reading
  logic       rise, start, stop, ack9;
  assign rise  = scl && !scl_q;
  assign start = scl && scl_q && sda_q && !sda;
  assign stop  = scl && scl_q && !sda_q && sda;
  assign ack9  = rise && (bit_q == BYTE_BITS);
  // ==========================================================================
  // bus tracker: next values
  always_comb begin
    bit_d = bit_q;
    sh_d  = sh_q;
    fst_d = fst_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    hi_d  = !scl ? 8'h00 : ((hi_q == 8'hFF) ? hi_q : hi_q + 8'h01);
    if (start || stop) begin
      // a condition drops any partial byte
      bit_d = 4'h0;
      fst_d = start;
      wr_d  = 1'b0;
      rd_d  = 1'b0;
    end else if (ack9) begin
      bit_d = 4'h0;
      fst_d = 1'b0;
      if (fst_q && sh_q[7:1] == TGT_ADDR7 && !sda) begin
        wr_d = !sh_q[0];
        rd_d = sh_q[0];
      end
    end else if (rise) begin
      bit_d = bit_q + 4'h1;
      sh_d  = {sh_q[6:0], sda};
    end
  end
  // registers only; reset makes the bus look idle
  always_ff @(posedge i_core_clk) begin
    if (i_srst) begin
      {sda_q, scl_q, bit_q, sh_q, hi_q, fst_q, wr_q, rd_q} <= {2'h3, 4'h0, 16'h0000, 3'h0};
    end else begin
      {sda_q, scl_q, bit_q, sh_q, hi_q, fst_q, wr_q, rd_q} <= {sda, scl, bit_d, sh_d, hi_d,
                                                               fst_d, wr_d, rd_d};
    end
  end
  // ==========================================================================
  // assertions
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_srst);
  rst_idle_a: assert property ($fell(i_srst) |-> !tgt_sda_oe && !ctl_sda_oe && !ctl_scl_oe)
    else $error("lines not released after reset");
  tgt_hold_a: assert property (!if_sel && scl && scl_q |-> $stable(tgt_sda_oe))
    else $error("target data moved while clock high");
  tgt_edge_a: assert property ($changed(tgt_sda_oe) && !$past(if_sel) |-> !scl && !scl_q)
    else $error("target data moved outside clock low");
  idle_quiet_a: assert property (hi_q > 8'h28 |-> !tgt_sda_oe)
    else $error("target pulls data on an idle bus");
  addr_ack_a: assert property (ack9 && fst_q && sh_q[7:1] == TGT_ADDR7 |-> tgt_sda_oe)
    else $error("own address not acknowledged");
  wr_ack_a: assert property (ack9 && wr_q |-> tgt_sda_oe)
    else $error("written byte not acknowledged");
  rd_free_a: assert property (ack9 && rd_q |-> !tgt_sda_oe)
    else $error("target holds data in host ack slot");
  sel_reset_a: assert property (if_sel && $past(if_sel) |-> !tgt_sda_oe && !ctl_sda_oe)
    else $error("select pin did not release the bus");
  start_owner_a: assert property (start |-> ctl_sda_oe && !tgt_sda_oe)
    else $error("start not made by the host end");
  // main scenarios
  wr_ack_c: cover property (ack9 && wr_q);
  rd_free_c: cover property (ack9 && rd_q);
  sel_c: cover property (if_sel);
endmodule

/* File: tb/tofi_tb_top.sv */
`timescale 1ns/1ps
// ==========================================================================
// bench: host end walks messages into the target end over one bus
module tofi_tb_top
  import tofi_pkg::*;
();
  logic        i_core_clk = 1'b0;  // 40 MHz core clock
  logic        i_srst     = 1'b1;  // held 16 cycles
  logic        cmd_valid  = 1'b0;  // command request
  logic        cmd_rnw    = 1'b0;  // 1 reads
  logic [15:0] cmd_idx    = 16'h0000;
  logic [7:0]  cmd_len    = 8'h01;
  logic [7:0]  wr_data    = 8'h00; // byte offered to the host end
  logic        bus_rst    = 1'b0;  // port reset request
  logic [7:0]  usr_idx    = 8'h00; // sensor-side read address
  logic        cmd_ready, wr_take, rd_valid, done, nack, wr_stb, busy;
  logic [7:0]  rd_data, usr_data, st_data;
  logic [15:0] st_idx;
  logic [7:0]  wbuf [8];           // bytes written, later expected back
  logic [7:0]  rbuf [8];           // bytes read back
  logic [7:0]  mon [4];            // bytes seen on the wire since the last start
  logic [7:0]  mon_sh = 8'h00;
  logic        sda_q = 1'b1, scl_q = 1'b1;
  int          mon_bit = 0, mon_n = 0, stb_n = 0, k;
  int          errors = 0, comparisons = 0;
  always #12.5 i_core_clk = ~i_core_clk;
  tofi_bus_if tofi_bus_if_i ();
  tofi_target #(.REG_AW(8)) tofi_target_i (
    .i_core_clk (i_core_clk), .i_srst (i_srst), .bus (tofi_bus_if_i.tgt),
    .i_usr_idx (usr_idx), .o_usr_data (usr_data), .o_wr_stb (wr_stb),
    .o_wr_idx (st_idx), .o_wr_data (st_data), .o_busy (busy));
  tofi_ctrl tofi_ctrl_i (
    .i_core_clk (i_core_clk), .i_srst (i_srst), .bus (tofi_bus_if_i.ctl),
    .i_cmd_valid (cmd_valid), .o_cmd_ready (cmd_ready), .i_cmd_rnw (cmd_rnw),
    .i_cmd_idx (cmd_idx), .i_cmd_len (cmd_len), .i_wr_data (wr_data), .o_wr_take (wr_take),
    .o_rd_data (rd_data), .o_rd_valid (rd_valid), .o_done (done), .o_nack (nack),
    .i_bus_rst (bus_rst));
  tofi_bus_properties tofi_bus_properties_i (
    .i_core_clk (i_core_clk), .i_srst (i_srst), .tgt_sda_oe (tofi_bus_if_i.tgt_sda_oe),
    .ctl_sda_oe (tofi_bus_if_i.ctl_sda_oe), .ctl_scl_oe (tofi_bus_if_i.ctl_scl_oe),
    .if_sel (tofi_bus_if_i.if_sel), .sda (tofi_bus_if_i.sda), .scl (tofi_bus_if_i.scl));
  always @(posedge i_core_clk) begin
    if (scl_q && tofi_bus_if_i.scl && sda_q && !tofi_bus_if_i.sda) begin
      mon_bit <= 0;
      mon_n   <= 0;
    end else if (tofi_bus_if_i.scl && !scl_q) begin
      mon_bit <= (mon_bit == 8) ? 0 : mon_bit + 1;
      if (mon_bit == 8 && mon_n < 4) begin
        mon[mon_n] <= mon_sh;
        mon_n      <= mon_n + 1;
      end
      mon_sh <= (mon_bit == 8) ? mon_sh : {mon_sh[6:0], tofi_bus_if_i.sda};
    end
    sda_q <= tofi_bus_if_i.sda;
    scl_q <= tofi_bus_if_i.scl;
    stb_n <= stb_n + ((wr_stb === 1'b1) ? 1 : 0);
  end
  // compare tasks: values up to 16 bits, and flags
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("ERROR at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  // command handshake: held until accepted
  task automatic send_cmd(input logic rnw, input logic [15:0] idx, input logic [7:0] len);
    int n;
    n = 0;
    @(negedge i_core_clk);
    cmd_valid = 1'b1;
    cmd_rnw   = rnw;
    cmd_idx   = idx;
    cmd_len   = len;
    wr_data   = wbuf[0];
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge i_core_clk);
      n++;
    end
    if (n == 100) begin
      errors++;
      $display("ERROR at %0t: command not accepted", $time);
    end
    @(negedge i_core_clk);
    cmd_valid = 1'b0;
  endtask
  // whole message: feed bytes on take, collect bytes after valid
  task automatic run_msg(input logic rnw, input logic [15:0] idx, input logic [7:0] len);
    int n, wk, rk;
    logic adv, pend;
    wk   = 0;
    rk   = 0;
    adv  = 1'b0;
    pend = 1'b0;
    send_cmd(rnw, idx, len);
    for (n = 0; n < 20000; n++) begin
      if (pend) begin
        rbuf[rk % 8] = rd_data;
        rk++;
      end
      if (adv) wr_data = wbuf[wk % 8];
      pend = (rd_valid === 1'b1);
      adv  = (wr_take === 1'b1);
      if (adv) wk++;
      if (done === 1'b1) break;
      @(negedge i_core_clk);
    end
    if (n == 20000) begin
      errors++;
      $display("ERROR at %0t: message did not finish", $time);
    end
  endtask
  // sensor-side view of one stored register
  task automatic peek(input logic [7:0] idx, input logic [7:0] exp);
    @(negedge i_core_clk);
    usr_idx = idx;
    repeat (2) @(negedge i_core_clk);
    chk_val({8'h00, usr_data}, {8'h00, exp}); // byte stored
  endtask
  task automatic conclude();
    $display("counts: %0d comparisons, %0d errors", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge i_core_clk);
    i_srst = 1'b0;
    @(negedge i_core_clk);
    chk_val({14'h0000, tofi_bus_if_i.sda, tofi_bus_if_i.scl}, 16'h0003); // lines idle high
    chk_bit(busy, 1'b0); // idle after reset
    $display("test reset done");
    for (k = 0; k < 8; k++) wbuf[k] = 8'h25 * k[7:0] + 8'h05;
    // write across the storage wrap, then stream it back and reread one byte
    run_msg(1'b0, 16'h00FE, 8'h04); // four bytes
    chk_val(stb_n[15:0], 16'h0004); // one store per byte
    chk_val(st_idx, 16'h0101); // index stepped
    chk_val({8'h00, st_data}, {8'h00, wbuf[3]}); // last byte stored
    chk_bit(nack, 1'b0); // all acked
    chk_val({mon[0], mon[3]}, {8'h52, wbuf[0]}); // address and data
    chk_val({mon[1], mon[2]}, 16'h00FE); // index high first
    for (k = 0; k < 4; k++) peek(8'hFE + k[7:0], wbuf[k]); // stored in order
    $display("test write done");
    run_msg(1'b1, 16'h00FE, 8'h04); // back to back
    for (k = 0; k < 4; k++) chk_val({8'h00, rbuf[k]}, {8'h00, wbuf[k]});
    chk_val({mon[0], mon[1]}, {8'h53, wbuf[0]}); // repeated start
    run_msg(1'b1, 16'hFF01, 8'h01); // single byte
    chk_val({8'h00, rbuf[0]}, {8'h00, wbuf[3]}); // low bits select
    chk_bit(nack, 1'b0); // index acked
    $display("test read done");
    // port reset in mid message
    send_cmd(1'b0, 16'h0040, 8'h01); // host opens message
    repeat (200) @(negedge i_core_clk);
    chk_bit(busy, 1'b1); // message open
    bus_rst = 1'b1;
    repeat (4) @(negedge i_core_clk);
    chk_val({14'h0000, tofi_bus_if_i.sda, tofi_bus_if_i.scl}, 16'h0003); // released
    chk_bit(cmd_ready, 1'b0); // host held
    bus_rst = 1'b0;
    repeat (4) @(negedge i_core_clk);
    chk_bit(busy, 1'b0); // target idle
    chk_val(stb_n[15:0], 16'h0004); // nothing stored
    for (k = 0; k < 8; k++) wbuf[k] = 8'hC3 ^ k[7:0];
    run_msg(1'b0, 16'h0040, 8'h02); // port usable
    run_msg(1'b1, 16'h0040, 8'h02); // read back
    for (k = 0; k < 2; k++) chk_val({8'h00, rbuf[k]}, {8'h00, wbuf[k]});
    $display("test port reset done");
    conclude();
  end
  // watchdog: all messages take well under 20000 cycles
  initial begin
    repeat (40000) @(posedge i_core_clk);
    errors++;
    $display("ERROR at %0t: watchdog expired", $time);
    conclude();
  end
endmodule
